// ===== hw/dpd_cfg.svh
// Constants of the packet download descriptor engine.
// Assumes 32-bit system memory words and byte addresses.
// How it works
// - Idle after reset; nonzero pointer write starts.
// - Pointer addresses the current head descriptor.
// - Fragment address and length fetched in turn.
// - Up to 63 fragments, 13-bit byte lengths.
// - Format from second dword bits 31:30.
// - Scheduled format shifts entries by four.
// - First dword links next; zero ends list.
// - Round length by boundary field unless bypassed.
// - Tag travels with packet, shown while sent.
// - Inhibit bit chooses supplied or computed CRC.
// - Underrun with inhibit forces a bad CRC.
// - Done interrupt on request, else errors only.
// - Write done bit after all fragments downloaded.
// - Bypass bit skips length round-up.
// - Reread control word for download-done notify.
// - Empty flag skips straight to next link.
`ifndef DL_CFG_SVH
`define DL_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define DL_REG_LIST_PTR 8'h00
`define DL_REG_STATUS 8'h04
`define DL_REG_TAG_VIEW 8'h08
// ****************************************
// Descriptor layout
// ****************************************
`define DL_OFF_FMT 32'h4
`define DL_OFF_CTRL_SCHED 32'h8
`define DL_OFF_FRAG 32'h8
`define DL_SCHED_SHIFT 32'h4
`define DL_MAX_FRAGS 63
`define DL_LEN_W 13
`define DL_FMT_HI 31
`define DL_FMT_LO 30
`define DL_FMT_SCHED 2'h1
`define DL_FMT_RSVD 2'h3
`define DL_FRAG_LAST 31
`define DL_RND_HI 1
`define DL_RND_LO 0
`define DL_TAG_HI 9
`define DL_TAG_LO 2
`define DL_FCS_INH 13
`define DL_TX_NOTIFY 15
`define DL_DONE 16
`define DL_BYPASS 28
`define DL_EMPTY 29
`define DL_DN_NOTIFY 31
`define DL_PTR_RST 32'h0
`endif

// ===== hw/dpd_pkg.sv
// Types of the packet download descriptor engine.
// Assumes the constants header is included by the users.
package dl_engine_pkg;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_LINK = 10'h002,
    S_FMT = 10'h004,
    S_CTRL = 10'h008,
    S_FADDR = 10'h010,
    S_FLEN = 10'h020,
    S_DATA = 10'h040,
    S_MARK = 10'h080,
    S_REREAD = 10'h100,
    S_NEXT = 10'h200
  } dl_state_e;
endpackage : dl_engine_pkg

// ===== hw/packet_download_descriptor_engine.sv
// Download engine: walks descriptors and streams fragments.
// Assumes a memory port that holds a request until ack, a MAC
// that returns each packet's sideband, and an AXI4-Lite master.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "dpd_cfg.svh"
module packet_download_descriptor_engine import dl_engine_pkg::*; #(
  parameter int MAX_FRAGS = `DL_MAX_FRAGS,
  parameter int LEN_W = `DL_LEN_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // System memory master
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  // Transmit FIFO stream
  output logic txValid,
  input wire logic txReady,
  output logic [31:0] txData,
  output logic [2:0] txBytes,
  output logic txLast,
  output logic [1:0] txPad,
  output logic [7:0] txTag,
  output logic txFcsInhibit,
  output logic txNotify,
  // MAC sideband of the packet on the wire
  input wire logic macStart,
  input wire logic [7:0] macTag,
  input wire logic macInhibit,
  input wire logic macNotify,
  input wire logic macDone,
  input wire logic macError,
  input wire logic macUnderrun,
  output logic fcsAppend,
  output logic fcsForceBad,
  output logic txDoneIrq,
  output logic dnDoneIrq
);
  // ****************************************
  // Register slave
  // ****************************************
  logic awHeld, wHeld, fmtErr, sendInhibit, sendNotify;
  logic [7:0] awAddrQ, tagView;
  logic [31:0] wDataQ, ptr, ctrl, link, fragAddr;
  logic [3:0] wStrbQ;
  dl_state_e state;
  wire commit = awHeld && wHeld && !bvalid;
  wire ptrHit = awAddrQ == `DL_REG_LIST_PTR;
  wire idle = state == S_IDLE;
  wire ptrWrite = commit && ptrHit && idle;
  wire [31:0] newPtr;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign newPtr[8*g+:8] = wStrbQ[g] ? wDataQ[8*g+:8] : ptr[8*g+:8];
    end
  endgenerate
  function automatic logic mapped(input logic [7:0] a);
    mapped = a == `DL_REG_LIST_PTR || a == `DL_REG_STATUS || a == `DL_REG_TAG_VIEW;
  endfunction : mapped
  assign awready = !awHeld;
  assign wready = !wHeld;
  assign arready = !rvalid;
  wire [31:0] statusWord = {6'h0, state, 14'h0, fmtErr, !idle};
  wire [31:0] readMux = araddr == `DL_REG_LIST_PTR ? ptr :
                        araddr == `DL_REG_STATUS ? statusWord :
                        araddr == `DL_REG_TAG_VIEW ? {24'h0, tagView} : 32'h0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 8'h0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (commit) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(awAddrQ) ? 2'h0 : 2'h2;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= readMux;
      rresp <= mapped(araddr) ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // ****************************************
  // Descriptor walker
  // ****************************************
  logic sched, fragLast;
  logic [5:0] fragIdx;
  logic [LEN_W-1:0] rem;
  logic [1:0] byteCnt;
  wire [1:0] fmt = memRdata[`DL_FMT_HI:`DL_FMT_LO];
  wire [31:0] ctrlOff = sched ? `DL_OFF_CTRL_SCHED : `DL_OFF_FMT;
  wire [31:0] fragBase = ptr + `DL_OFF_FRAG + (sched ? `DL_SCHED_SHIFT : 32'h0)
                         + 32'({fragIdx, 3'h0});
  wire lastFrag = fragLast || fragIdx == 6'(MAX_FRAGS - 1);
  wire [2:0] beatBytes = rem >= LEN_W'(4) ? 3'h4 : rem[2:0];
  wire [LEN_W-1:0] remAfter = rem - LEN_W'(beatBytes);
  wire [1:0] sumLow = 2'(byteCnt + beatBytes[1:0]);
  wire [1:0] rnd = ctrl[`DL_RND_HI:`DL_RND_LO];
  wire [1:0] padCalc = (ctrl[`DL_BYPASS] || rnd[0]) ? 2'h0 :
                       rnd[1] ? {1'b0, sumLow[0]} : 2'(2'h0 - sumLow);
  wire beatDone = txValid && txReady;
  always_comb begin
    memReq = 1'b0;
    memWrite = 1'b0;
    memAddr = ptr;
    memWdata = 32'h0;
    case (state)
      S_LINK: memReq = 1'b1;
      S_FMT: begin
        memReq = 1'b1;
        memAddr = ptr + `DL_OFF_FMT;
      end
      S_CTRL: begin
        memReq = 1'b1;
        memAddr = ptr + `DL_OFF_CTRL_SCHED;
      end
      S_FADDR: begin
        memReq = 1'b1;
        memAddr = fragBase;
      end
      S_FLEN: begin
        memReq = 1'b1;
        memAddr = fragBase + 32'h4;
      end
      S_DATA: begin
        memReq = !txValid && rem != '0;
        memAddr = fragAddr;
      end
      S_MARK: begin
        memReq = 1'b1;
        memWrite = 1'b1;
        memAddr = ptr + ctrlOff;
        memWdata = ctrl | (32'h1 << `DL_DONE);
      end
      S_REREAD: begin
        memReq = 1'b1;
        memAddr = ptr + ctrlOff;
      end
      default: memReq = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      ptr <= `DL_PTR_RST;
      link <= 32'h0;
      ctrl <= 32'h0;
      sched <= 1'b0;
      fmtErr <= 1'b0;
      fragIdx <= 6'h0;
      fragAddr <= 32'h0;
      fragLast <= 1'b0;
      rem <= '0;
      byteCnt <= 2'h0;
      dnDoneIrq <= 1'b0;
    end else begin
      dnDoneIrq <= 1'b0;
      case (state)
        S_IDLE: if (ptrWrite) begin
          ptr <= newPtr;
          fmtErr <= 1'b0;
          if (newPtr != 32'h0) state <= S_LINK;
        end
        S_LINK: if (memAck) begin
          link <= memRdata;
          state <= S_FMT;
        end
        S_FMT: if (memAck) begin
          fragIdx <= 6'h0;
          byteCnt <= 2'h0;
          sched <= fmt == `DL_FMT_SCHED;
          if (fmt == `DL_FMT_RSVD) begin
            fmtErr <= 1'b1;
            state <= S_IDLE;
          end else if (fmt == `DL_FMT_SCHED) begin
            state <= S_CTRL;
          end else begin
            ctrl <= memRdata;
            state <= memRdata[`DL_EMPTY] ? S_NEXT : S_FADDR;
          end
        end
        S_CTRL: if (memAck) begin
          ctrl <= memRdata;
          state <= memRdata[`DL_EMPTY] ? S_NEXT : S_FADDR;
        end
        S_FADDR: if (memAck) begin
          fragAddr <= memRdata;
          state <= S_FLEN;
        end
        S_FLEN: if (memAck) begin
          rem <= memRdata[LEN_W-1:0];
          fragLast <= memRdata[`DL_FRAG_LAST];
          state <= S_DATA;
        end
        S_DATA: begin
          if (memAck) begin
            rem <= remAfter;
            fragAddr <= fragAddr + 32'h4;
            byteCnt <= sumLow;
          end
          if ((beatDone && rem == '0) || (!txValid && rem == '0)) begin
            fragIdx <= 6'(fragIdx + 6'h1);
            state <= lastFrag ? S_MARK : S_FADDR;
          end
        end
        S_MARK: if (memAck) state <= S_REREAD;
        S_REREAD: if (memAck) begin
          dnDoneIrq <= memRdata[`DL_DN_NOTIFY];
          state <= S_NEXT;
        end
        S_NEXT: begin
          ptr <= link;
          state <= link == 32'h0 ? S_IDLE : S_LINK;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // ****************************************
  // Transmit stream and MAC sideband
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txValid <= 1'b0;
      txData <= 32'h0;
      txBytes <= 3'h0;
      txLast <= 1'b0;
      txPad <= 2'h0;
      txTag <= 8'h0;
      txFcsInhibit <= 1'b0;
      txNotify <= 1'b0;
    end else begin
      if (state == S_DATA && memAck) begin
        txValid <= 1'b1;
        txData <= memRdata;
        txBytes <= beatBytes;
        txLast <= remAfter == '0 && lastFrag;
        txPad <= padCalc;
        txTag <= ctrl[`DL_TAG_HI:`DL_TAG_LO];
        txFcsInhibit <= ctrl[`DL_FCS_INH];
        txNotify <= ctrl[`DL_TX_NOTIFY];
      end else if (beatDone) begin
        txValid <= 1'b0;
      end
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tagView <= 8'h0;
      sendInhibit <= 1'b0;
      sendNotify <= 1'b0;
      fcsAppend <= 1'b1;
      fcsForceBad <= 1'b0;
      txDoneIrq <= 1'b0;
    end else begin
      if (macStart) begin
        tagView <= macTag;
        sendInhibit <= macInhibit;
        sendNotify <= macNotify;
      end
      fcsAppend <= !sendInhibit || macUnderrun;
      fcsForceBad <= sendInhibit && macUnderrun;
      txDoneIrq <= (macDone && sendNotify) || macError;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_idle_start: assert property (idle && ptrWrite && newPtr != 0 |=> state == S_LINK)
    else $error("start not taken");
  a_idle_hold: assert property (idle && !ptrWrite |=> idle)
    else $error("left idle alone");
  a_link_head: assert property (state == S_LINK && memReq |-> memAddr == ptr)
    else $error("link not at head");
  a_resv_stop: assert property (state == S_FMT && memAck && fmt == 2'h3
    |=> idle && fmtErr)
    else $error("reserved format ran");
  a_sched_ctrl: assert property (state == S_FMT && memAck && fmt == 2'h1
    |=> state == S_CTRL && memAddr == ptr + 32'h8)
    else $error("control not shifted");
  a_frag_cap: assert property (state == S_DATA |-> fragIdx < 6'(MAX_FRAGS))
    else $error("fragment count overrun");
  a_empty_skip: assert property (memAck && memRdata[29] && (state == S_CTRL
    || (state == S_FMT && !memRdata[30])) |=> state == S_NEXT ##1 ptr == $past(link))
    else $error("empty not skipped");
  a_done_mark: assert property (state == S_MARK |-> memWrite && memWdata[16])
    else $error("done bit missing");
  a_end_idle: assert property (state == S_NEXT && link == 0 |=> idle)
    else $error("zero link kept going");
  a_ptr_adv: assert property (state == S_NEXT |=> ptr == $past(link))
    else $error("pointer not advanced");
  a_bad_fcs: assert property (sendInhibit && macUnderrun && !macStart
    |=> fcsForceBad && fcsAppend)
    else $error("bad crc not forced");
  a_word_pad: assert property (txValid && txLast && !ctrl[28] && ctrl[1:0] == 2'h2
    |-> txPad <= 2'h1)
    else $error("word pad too big");
  c_sched: cover property (state == S_CTRL ##[1:20] state == S_DATA);
  c_empty: cover property ((state == S_FMT || state == S_CTRL) ##1 state == S_NEXT);
  c_packet: cover property (txValid && txReady && txLast ##[1:20] dnDoneIrq);
  c_chain: cover property (state == S_NEXT && link != 0);
endmodule : packet_download_descriptor_engine

// ===== verif/host_memory_model.sv
// Host memory answering the engine's memory port.
// Assumes each request is held until memAck.
`timescale 1ns/100ps
module host_memory_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Memory port
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] mem [0:2047];
  logic [31:0] noise;
  logic [1:0] lat;
  logic [1:0] waitN;
  // Data outside an answer toggles each cycle
  assign memRdata = memAck ? mem[memAddr[12:2]] : noise;
  // Latency walks 0..3 cycles
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      memAck <= 1'b0;
      lat <= 2'h0;
      waitN <= 2'h0;
      noise <= 32'h5a5a_c3c3;
    end else begin
      noise <= ~{noise[30:0], noise[31]};
      memAck <= 1'b0;
      if (memReq && !memAck) begin
        waitN <= waitN + 2'h1;
        if (waitN == lat) begin
          memAck <= 1'b1;
          waitN <= 2'h0;
          lat <= lat + 2'h1;
          if (memWrite) mem[memAddr[12:2]] <= memWdata;
        end
      end
    end
  end
endmodule : host_memory_model

// ===== verif/packet_download_descriptor_engine_tb_top.sv
// Bench: descriptor chain, stream, MAC sideband, registers.
// Assumes the design files and memory model compile first.
`timescale 1ns/100ps
`include "dpd_cfg.svh"
module packet_download_descriptor_engine_tb_top;
  logic core_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, memReq, memWrite, memAck;
  logic txValid, txReady, txLast, txFcsInhibit, txNotify, macStart, macInhibit;
  logic macNotify, macDone, macError, macUnderrun, fcsAppend, fcsForceBad;
  logic txDoneIrq, dnDoneIrq;
  logic [7:0] awaddr, araddr, txTag, macTag;
  logic [31:0] wdata, rdata, memAddr, memWdata, memRdata, txData, rnd, d;
  logic [31:0] ca [5];
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, txPad, r;
  logic [2:0] txBytes;
  logic [47:0] o;
  logic [47:0] exp[$];
  logic [4:0] mc [4] = '{5'h0c, 5'h14, 5'h13, 5'h03};
  int mismatches, cmp_count, cycles, txIrqN, dnIrqN, n;

  packet_download_descriptor_engine packet_download_descriptor_engine_inst (
    .core_clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata, .txValid,
    .txReady, .txData, .txBytes, .txLast, .txPad, .txTag, .txFcsInhibit, .txNotify,
    .macStart, .macTag, .macInhibit, .macNotify, .macDone, .macError, .macUnderrun,
    .fcsAppend, .fcsForceBad, .txDoneIrq, .dnDoneIrq);
  host_memory_model host_memory_model_inst (.core_clk, .nrst, .memReq, .memWrite,
    .memAddr, .memWdata, .memAck, .memRdata);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    cmp_count++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic put(input logic [31:0] a, input logic [31:0] v);
    host_memory_model_inst.mem[a[12:2]] = v;
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wait_idle();
    do rd(`DL_REG_STATUS); while (d[0] !== 1'b0);
  endtask : wait_idle
  // Chain of five: basic, scheduled, no round, bypass, empty
  task automatic build();
    logic [31:0] b, e, fa, c;
    for (int i = 0; i < 5; i++) begin
      b = 32'h100 * (i + 1);
      fa = 32'h1000 + 32'h20 * i;
      c = {i == 1 || i == 3, 1'b0, i == 4, i == 3, 12'h0, i[1], 1'b0, i[0], 3'h0,
        8'ha0 + i[7:0], i == 1 ? 2'h2 : i == 2 ? 2'h1 : 2'h0};
      put(b, i == 4 ? 32'h0 : b + 32'h100);
      e = b + 32'h4;
      if (i == 1) begin
        put(e, 32'h4000_0000);
        e = e + 32'h4;
      end
      ca[i] = e;
      put(e, c);
      put(e + 4, fa);
      put(e + 8, 32'h4);
      put(e + 12, fa + 16);
      put(e + 16, 32'h8000_0001);
      rnd = lfsr(rnd);
      put(fa, rnd);
      if (i < 4) exp.push_back({i[1], i[0], c[9:2], 2'h0, 1'b0, 3'h4, rnd});
      rnd = lfsr(rnd);
      put(fa + 16, rnd);
      if (i < 4) exp.push_back({i[1], i[0], c[9:2], i == 0 ? 2'h3 : {1'b0, i == 1},
        1'b1, 3'h1, 24'h0, rnd[7:0]});
    end
  endtask : build

  // ****************************************
  // Clock, stall, stream monitor, timeout
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rnd = lfsr(rnd);
    txReady <= rnd[0] | rnd[3];
    cycles++;
    if (txDoneIrq === 1'b1) txIrqN++;
    if (dnDoneIrq === 1'b1) dnIrqN++;
    if (txValid && txReady) begin
      o = {txNotify, txFcsInhibit, txTag, txLast ? txPad : 2'h0, txLast, txBytes,
        txData & (32'hffff_ffff >> (8 * (4 - txBytes)))};
      check(o, exp.size() ? exp.pop_front() : ~o);
    end
    if (cycles > 20000) begin
      mismatches++;
      complete_run();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, txReady, macStart} = '0;
    {macInhibit, macNotify, macDone, macError, macUnderrun, awaddr, araddr} = '0;
    {macTag, wdata} = '0;
    wstrb = 4'hf;
    rnd = 32'h883f;
    build();
    put(32'h800, 32'h0);
    put(32'h804, 32'hc000_0000);
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rd(`DL_REG_LIST_PTR);
    check(d, `DL_PTR_RST);
    wr(`DL_REG_LIST_PTR, 32'h0);
    rd(`DL_REG_STATUS);
    check(d[0], 1'b0);
    rd(8'h0c);
    check({r, d}, 34'h2_0000_0000);
    wr(8'h10, 32'h0);
    check(r, 2'h2);
    $display("test 1 done");
    wr(`DL_REG_LIST_PTR, 32'h100);
    wr(`DL_REG_LIST_PTR, 32'h800);
    wait_idle();
    check(d[1:0], 2'h0);
    check(exp.size(), 0);
    for (int i = 0; i < 5; i++) begin
      check(host_memory_model_inst.mem[ca[i][12:2]][16], i < 4);
    end
    check(dnIrqN, 2);
    rd(`DL_REG_LIST_PTR);
    check(d, 32'h0);
    $display("test 2 done");
    wr(`DL_REG_LIST_PTR, 32'h800);
    wait_idle();
    check(d[1:0], 2'h2);
    $display("test 3 done");
    for (int k = 0; k < 4; k++) begin
      n = txIrqN;
      @(posedge core_clk);
      macStart <= 1'b1;
      macTag <= 8'h30 + k[7:0];
      {macInhibit, macNotify} <= mc[k][4:3];
      @(posedge core_clk);
      macStart <= 1'b0;
      {macDone, macError, macUnderrun} <= mc[k][2:0];
      @(posedge core_clk);
      {macDone, macError, macUnderrun} <= 3'h0;
      @(negedge core_clk);
      check(fcsAppend, !mc[k][4] | mc[k][0]);
      check(fcsForceBad, mc[k][4] & mc[k][0]);
      rd(`DL_REG_TAG_VIEW);
      check(d[7:0], 8'h30 + k[7:0]);
      check(txIrqN - n, mc[k][3] & mc[k][2] | mc[k][1]);
    end
    $display("test 4 done");
    complete_run();
  end
endmodule : packet_download_descriptor_engine_tb_top
